/* File: spi_rate_params.svh */
// Constants for the serial port control-two and bit-rate block.
// Included by the package and by the design; definitions only.
`ifndef SPI_RATE_PARAMS_SVH
`define SPI_RATE_PARAMS_SVH

// Register indices; byte address is four times the index
`define IDX_CTRL_TWO    12'h0E9
`define IDX_RATE_SEL    12'h0EA
`define IDX_MODE        12'h0F0
`define IDX_IRQ_STATUS  12'h0F1
`define IDX_IRQ_MASK    12'h0F2

// Control-two field positions
`define BIT_FAULT_EN    4
`define BIT_LINE_OE     3
`define BIT_WAIT_STOP   1
`define BIT_PIN_CTRL    0
`define CTRL_TWO_MASK   8'h1B

// Bit-rate field positions
`define PRESCALE_MSB    6
`define PRESCALE_LSB    4
`define EXPONENT_MSB    2
`define EXPONENT_LSB    0
`define RATE_SEL_MASK   8'h77

// Mode register field positions
`define BIT_MASTER      0
`define BIT_ENABLE      1
`define BIT_POLARITY    2
`define BIT_SEL_OE      3
`define MODE_MASK       8'h0F

// Interrupt status bits
`define IRQ_ABORT       0
`define IRQ_FAULT       1
`define IRQ_MASK_BITS   8'h03

// Reset values
`define CTRL_TWO_RST    8'h00
`define RATE_SEL_RST    8'h00
`define MODE_RST        8'h00

// AXI responses
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2

`endif

/* File: spi_rate_pkg.sv */
// Types shared by the control-two and bit-rate block.
// Assumes spi_rate_params.svh is on the include path.
`include "spi_rate_params.svh"

package spi_rate_pkg;

  // Serial clock generator states, one-hot
  typedef enum logic [1:0] {
    SCK_IDLE = 2'h1,
    SCK_RUN  = 2'h2
  } sck_state_t;

endpackage : spi_rate_pkg

/* File: spi_rate_ctrl.sv */
// Control-two and bit-rate logic of a serial port with an AXI4-Lite slave.
// Assumes a shift engine beside it that starts on xfer_start, counts sck_edge
// pulses, drops xfer_busy when done, and obeys abort_idle.
// Summary of operation
// - Mode fault checking happens only while the fault-detect enable bit 4 is set.
// - Master with fault-detect cleared: select pin not used at all.
// - Slave: select pin is an input whatever fault-detect holds.
// - Master: changing fault-detect or pin control aborts transfer, returns idle.
// - Single-line mode: bit 3 enables the data-out buffer, master or slave pin.
// - Master single-line: changing output-buffer enable aborts the transfer.
// - Wait clock stop bit 1 halts serial clock generation during wait mode.
// - Master normal mode: receive on MISO, drive MOSI, ignore buffer enable.
// - Master single-line: MISO unused, MOSI input, or input/output when enabled.
// - Slave: drive MISO, receive MOSI; single-line uses MISO only.
// - Both registers read and write anytime; reserved bits ignore writes.
// - Master: changing prescale or exponent fields aborts transfer, returns idle.
// - Divisor is (prescale plus one) times two to the (exponent plus one).
// - Prescale bits 6..4, exponent bits 2..0; bits 7 and 3 read zero.
// - Master bit rate equals bus clock divided by the divisor.
// - Master with fault-detect: select output when enabled, else fault input.
//
// Register access over AXI4-Lite is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
`include "spi_rate_params.svh"

module spi_rate_ctrl #(
  parameter int ADDR_W = 12
) (
  // Clock and reset
  input  wire  logic              aclk,
  input  wire  logic              aresetn,
  // AXI4-Lite write address
  input  wire  logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire  logic              s_axi_awvalid,
  output logic                    s_axi_awready,
  // AXI4-Lite write data
  input  wire  logic [31:0]       s_axi_wdata,
  input  wire  logic [3:0]        s_axi_wstrb,
  input  wire  logic              s_axi_wvalid,
  output logic                    s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]              s_axi_bresp,
  output logic                    s_axi_bvalid,
  input  wire  logic              s_axi_bready,
  // AXI4-Lite read address
  input  wire  logic [ADDR_W-1:0] s_axi_araddr,
  input  wire  logic              s_axi_arvalid,
  output logic                    s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]             s_axi_rdata,
  output logic [1:0]              s_axi_rresp,
  output logic                    s_axi_rvalid,
  input  wire  logic              s_axi_rready,
  // Shift engine and system side
  input  wire  logic              wait_mode,
  input  wire  logic              xfer_start,
  input  wire  logic              xfer_busy,
  input  wire  logic              sel_level,
  output logic                    abort_idle,
  output logic                    sck_edge,
  output logic                    rx_from_mosi,
  output logic                    mode_fault_flag,
  output logic                    irq,
  // Pins, split into input, output and enable
  input  wire  logic              sel_pin_in,
  output logic                    sel_pin_out,
  output logic                    sel_pin_oe,
  output logic                    sck_pin_out,
  output logic                    sck_pin_oe,
  output logic                    mosi_oe,
  output logic                    miso_oe
);

  localparam int AW = ADDR_W;

  // Register state
  logic [7:0]  ctrl_two_r, ctrl_two_nxt;
  logic [7:0]  rate_sel_r, rate_sel_nxt;
  logic [7:0]  mode_r, mode_nxt;
  logic [7:0]  irq_stat_r, irq_stat_nxt;
  logic [7:0]  irq_mask_r, irq_mask_nxt;
  // Bus state
  logic          awready_r, awready_nxt, wready_r, wready_nxt;
  logic          aw_held_r, aw_held_nxt, w_held_r, w_held_nxt;
  logic [AW-1:0] awaddr_r, awaddr_nxt;
  logic [31:0]   wdata_r, wdata_nxt;
  logic          wstrb0_r, wstrb0_nxt;
  logic          bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt, arready_r, arready_nxt;
  logic [1:0]    bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic [31:0]   rdata_r, rdata_nxt;
  // Serial clock and pins
  spi_rate_pkg::sck_state_t sck_st_r, sck_st_nxt;
  logic [10:0] half_cnt_r, half_cnt_nxt;
  logic        sck_r, sck_nxt, edge_r, edge_nxt, abort_r, abort_nxt;
  logic        sel_meta_r, sel_sync_r, fault_r, fault_nxt, irq_r, irq_nxt;
  logic        sel_out_r, sel_out_nxt, sel_oe_r, sel_oe_nxt;
  logic        mosi_oe_r, mosi_oe_nxt, miso_oe_r, miso_oe_nxt, rx_mosi_r, rx_mosi_nxt;
  logic        sck_oe_r, sck_oe_nxt;

  // Decoded fields
  logic        is_master, fault_en, line_oe, pin_ctrl, wait_stop, sel_oe_en;
  logic [2:0]  prescale, exponent;
  logic [10:0] half_period;
  logic        do_write, abort_req, fault_evt;
  logic [ADDR_W-3:0] wr_idx, rd_idx;
  logic [7:0]  wbyte;

  assign is_master = mode_r[`BIT_MASTER] & mode_r[`BIT_ENABLE];
  assign fault_en  = ctrl_two_r[`BIT_FAULT_EN];
  assign line_oe   = ctrl_two_r[`BIT_LINE_OE];
  assign pin_ctrl  = ctrl_two_r[`BIT_PIN_CTRL];
  assign wait_stop = ctrl_two_r[`BIT_WAIT_STOP];
  assign sel_oe_en = mode_r[`BIT_SEL_OE];
  assign prescale  = rate_sel_r[`PRESCALE_MSB:`PRESCALE_LSB];
  assign exponent  = rate_sel_r[`EXPONENT_MSB:`EXPONENT_LSB];
  // Half of the divisor: (prescale+1) * 2^exponent bus cycles per clock phase
  assign half_period = 11'({8'h00, prescale} + 11'h001) << exponent;
  assign do_write  = aw_held_r & w_held_r & ~bvalid_r;
  assign wr_idx    = awaddr_r[AW-1:2];
  assign rd_idx    = s_axi_araddr[AW-1:2];
  assign wbyte     = wdata_r[7:0];

  // Write channels, register updates and abort detection
  always_comb begin
    awready_nxt  = awready_r;
    wready_nxt   = wready_r;
    aw_held_nxt  = aw_held_r;
    w_held_nxt   = w_held_r;
    awaddr_nxt   = awaddr_r;
    wdata_nxt    = wdata_r;
    wstrb0_nxt   = wstrb0_r;
    bvalid_nxt   = bvalid_r;
    bresp_nxt    = bresp_r;
    ctrl_two_nxt = ctrl_two_r;
    rate_sel_nxt = rate_sel_r;
    mode_nxt     = mode_r;
    irq_mask_nxt = irq_mask_r;
    abort_req    = 1'b0;
    // Address and data are taken in either order
    if (s_axi_awvalid && awready_r) begin
      aw_held_nxt = 1'b1;
      awaddr_nxt  = s_axi_awaddr;
      awready_nxt = 1'b0;
    end
    if (s_axi_wvalid && wready_r) begin
      w_held_nxt = 1'b1;
      wdata_nxt  = s_axi_wdata;
      wstrb0_nxt = s_axi_wstrb[0];
      wready_nxt = 1'b0;
    end
    if (do_write) begin
      bvalid_nxt  = 1'b1;
      bresp_nxt   = `RESP_OKAY;
      aw_held_nxt = 1'b0;
      w_held_nxt  = 1'b0;
      if (wr_idx == (ADDR_W-2)'(`IDX_CTRL_TWO)) begin
        if (wstrb0_r) begin
          ctrl_two_nxt = wbyte & `CTRL_TWO_MASK;
          if (is_master && ((ctrl_two_nxt[`BIT_FAULT_EN] != fault_en) ||
                            (ctrl_two_nxt[`BIT_PIN_CTRL] != pin_ctrl))) begin
            abort_req = 1'b1;
          end
          if (is_master && pin_ctrl && (ctrl_two_nxt[`BIT_LINE_OE] != line_oe)) begin
            abort_req = 1'b1;
          end
        end
      end else if (wr_idx == (ADDR_W-2)'(`IDX_RATE_SEL)) begin
        if (wstrb0_r) begin
          rate_sel_nxt = wbyte & `RATE_SEL_MASK;
          abort_req    = is_master && (rate_sel_nxt != rate_sel_r);
        end
      end else if (wr_idx == (ADDR_W-2)'(`IDX_MODE)) begin
        if (wstrb0_r) begin
          mode_nxt = wbyte & `MODE_MASK;
        end
      end else if (wr_idx == (ADDR_W-2)'(`IDX_IRQ_MASK)) begin
        if (wstrb0_r) begin
          irq_mask_nxt = wbyte & `IRQ_MASK_BITS;
        end
      end else if (wr_idx == (ADDR_W-2)'(`IDX_IRQ_STATUS)) begin
        bresp_nxt = `RESP_OKAY; // Status clears only by read
      end else begin
        bresp_nxt = `RESP_SLVERR;
      end
    end
    if (bvalid_r && s_axi_bready) begin
      bvalid_nxt  = 1'b0;
      awready_nxt = 1'b1;
      wready_nxt  = 1'b1;
    end
  end

  // Read channel; a status read clears its sticky bits
  always_comb begin
    arready_nxt  = arready_r;
    rvalid_nxt   = rvalid_r;
    rdata_nxt    = rdata_r;
    rresp_nxt    = rresp_r;
    irq_stat_nxt = irq_stat_r;
    if (s_axi_arvalid && arready_r) begin
      arready_nxt = 1'b0;
      rvalid_nxt  = 1'b1;
      rresp_nxt   = `RESP_OKAY;
      rdata_nxt   = 32'h0000_0000;
      if (rd_idx == (ADDR_W-2)'(`IDX_CTRL_TWO)) begin
        rdata_nxt[7:0] = ctrl_two_r;
      end else if (rd_idx == (ADDR_W-2)'(`IDX_RATE_SEL)) begin
        rdata_nxt[7:0] = rate_sel_r;
      end else if (rd_idx == (ADDR_W-2)'(`IDX_MODE)) begin
        rdata_nxt[7:0] = mode_r;
      end else if (rd_idx == (ADDR_W-2)'(`IDX_IRQ_STATUS)) begin
        rdata_nxt[7:0] = irq_stat_r;
        irq_stat_nxt   = 8'h00;
      end else if (rd_idx == (ADDR_W-2)'(`IDX_IRQ_MASK)) begin
        rdata_nxt[7:0] = irq_mask_r;
      end else begin
        rresp_nxt = `RESP_SLVERR;
      end
    end
    if (rvalid_r && s_axi_rready) begin
      rvalid_nxt  = 1'b0;
      arready_nxt = 1'b1;
    end
    // Set after clear so a new event is never lost
    if (abort_req) begin
      irq_stat_nxt[`IRQ_ABORT] = 1'b1;
    end
    if (fault_evt) begin
      irq_stat_nxt[`IRQ_FAULT] = 1'b1;
    end
    irq_nxt = |((irq_stat_nxt & irq_mask_nxt));
  end

  // Fault check: only as master with fault-detect set and select as input
  assign fault_evt = is_master && fault_en && !sel_oe_en && !sel_sync_r;

  // Serial clock generator; idle parks the clock at its polarity
  always_comb begin
    sck_st_nxt   = sck_st_r;
    half_cnt_nxt = half_cnt_r;
    sck_nxt      = sck_r;
    edge_nxt     = 1'b0;
    abort_nxt    = abort_req || fault_evt;
    fault_nxt    = fault_evt;
    case (sck_st_r)
      spi_rate_pkg::SCK_IDLE: begin
        sck_nxt      = mode_r[`BIT_POLARITY];
        half_cnt_nxt = 11'h000;
        if (xfer_start && is_master && !abort_nxt) begin
          sck_st_nxt = spi_rate_pkg::SCK_RUN;
        end
      end
      spi_rate_pkg::SCK_RUN: begin
        if (abort_nxt || !xfer_busy || !is_master) begin
          sck_st_nxt = spi_rate_pkg::SCK_IDLE;
          sck_nxt    = mode_r[`BIT_POLARITY];
        end else if (wait_mode && wait_stop) begin
          half_cnt_nxt = half_cnt_r;
        end else if (half_cnt_r == half_period - 11'h001) begin
          half_cnt_nxt = 11'h000;
          sck_nxt      = ~sck_r;
          edge_nxt     = 1'b1;
        end else begin
          half_cnt_nxt = half_cnt_r + 11'h001;
        end
      end
      default: begin
        sck_st_nxt = spi_rate_pkg::SCK_IDLE;
      end
    endcase
  end

  // Pin roles from mode, single-line control and buffer enable
  always_comb begin
    sel_oe_nxt  = 1'b0;
    sel_out_nxt = 1'b1;
    mosi_oe_nxt = 1'b0;
    miso_oe_nxt = 1'b0;
    rx_mosi_nxt = 1'b0;
    sck_oe_nxt  = is_master;
    if (is_master) begin
      if (fault_en && sel_oe_en) begin
        sel_oe_nxt  = 1'b1;
        sel_out_nxt = sel_level;
      end // Fault-detect clear leaves the pin to the port logic
      if (!pin_ctrl) begin
        mosi_oe_nxt = 1'b1;
      end else begin
        mosi_oe_nxt = line_oe;
        rx_mosi_nxt = 1'b1;
      end
    end else if (mode_r[`BIT_ENABLE]) begin
      // Select stays an input in slave mode
      if (!pin_ctrl) begin
        miso_oe_nxt = 1'b1;
        rx_mosi_nxt = 1'b1;
      end else begin
        miso_oe_nxt = line_oe;
      end
    end
  end

  // All registered state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_two_r <= `CTRL_TWO_RST;
      rate_sel_r <= `RATE_SEL_RST;
      mode_r     <= `MODE_RST;
      irq_stat_r <= 8'h00;
      irq_mask_r <= 8'h00;
      awready_r  <= 1'b1;
      wready_r   <= 1'b1;
      aw_held_r  <= 1'b0;
      w_held_r   <= 1'b0;
      awaddr_r   <= '0;
      wdata_r    <= 32'h0000_0000;
      wstrb0_r   <= 1'b0;
      bvalid_r   <= 1'b0;
      bresp_r    <= `RESP_OKAY;
      arready_r  <= 1'b1;
      rvalid_r   <= 1'b0;
      rdata_r    <= 32'h0000_0000;
      rresp_r    <= `RESP_OKAY;
      sck_st_r   <= spi_rate_pkg::SCK_IDLE;
      half_cnt_r <= 11'h000;
      sck_r      <= 1'b0;
      edge_r     <= 1'b0;
      abort_r    <= 1'b0;
      fault_r    <= 1'b0;
      irq_r      <= 1'b0;
      sel_meta_r <= 1'b1;
      sel_sync_r <= 1'b1;
      sel_out_r  <= 1'b1;
      sel_oe_r   <= 1'b0;
      mosi_oe_r  <= 1'b0;
      miso_oe_r  <= 1'b0;
      rx_mosi_r  <= 1'b0;
      sck_oe_r   <= 1'b0;
    end else begin
      ctrl_two_r <= ctrl_two_nxt;
      rate_sel_r <= rate_sel_nxt;
      mode_r     <= mode_nxt;
      irq_stat_r <= irq_stat_nxt;
      irq_mask_r <= irq_mask_nxt;
      awready_r  <= awready_nxt;
      wready_r   <= wready_nxt;
      aw_held_r  <= aw_held_nxt;
      w_held_r   <= w_held_nxt;
      awaddr_r   <= awaddr_nxt;
      wdata_r    <= wdata_nxt;
      wstrb0_r   <= wstrb0_nxt;
      bvalid_r   <= bvalid_nxt;
      bresp_r    <= bresp_nxt;
      arready_r  <= arready_nxt;
      rvalid_r   <= rvalid_nxt;
      rdata_r    <= rdata_nxt;
      rresp_r    <= rresp_nxt;
      sck_st_r   <= sck_st_nxt;
      half_cnt_r <= half_cnt_nxt;
      sck_r      <= sck_nxt;
      edge_r     <= edge_nxt;
      abort_r    <= abort_nxt;
      fault_r    <= fault_nxt;
      irq_r      <= irq_nxt;
      sel_meta_r <= sel_pin_in; // Pin is asynchronous, two stages
      sel_sync_r <= sel_meta_r;
      sel_out_r  <= sel_out_nxt;
      sel_oe_r   <= sel_oe_nxt;
      mosi_oe_r  <= mosi_oe_nxt;
      miso_oe_r  <= miso_oe_nxt;
      rx_mosi_r  <= rx_mosi_nxt;
      sck_oe_r   <= sck_oe_nxt;
    end
  end

  // Outputs straight from flip-flops
  assign s_axi_awready   = awready_r;
  assign s_axi_wready    = wready_r;
  assign s_axi_bvalid    = bvalid_r;
  assign s_axi_bresp     = bresp_r;
  assign s_axi_arready   = arready_r;
  assign s_axi_rvalid    = rvalid_r;
  assign s_axi_rdata     = rdata_r;
  assign s_axi_rresp     = rresp_r;
  assign abort_idle      = abort_r;
  assign sck_edge        = edge_r;
  assign rx_from_mosi    = rx_mosi_r;
  assign mode_fault_flag = fault_r;
  assign irq             = irq_r;
  assign sel_pin_out     = sel_out_r;
  assign sel_pin_oe      = sel_oe_r;
  assign sck_pin_out     = sck_r;
  assign sck_pin_oe      = sck_oe_r;
  assign mosi_oe         = mosi_oe_r;
  assign miso_oe         = miso_oe_r;

endmodule : spi_rate_ctrl
`default_nettype wire

/* File: spi_rate_checker.sv */
// Concurrent checks on the control-two and bit-rate block.
// Sees only top ports; mirrors accepted register writes from the write channel.
`timescale 1ns/1ps
`default_nettype none
`include "spi_rate_params.svh"

module spi_rate_checker #(
  parameter int ADDR_W = 12
) (
  // Clock and reset
  input wire logic              aclk,
  input wire logic              aresetn,
  // Register write path
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic              s_axi_awvalid,
  input wire logic              s_axi_awready,
  input wire logic [31:0]       s_axi_wdata,
  input wire logic [3:0]        s_axi_wstrb,
  input wire logic              s_axi_wvalid,
  input wire logic              s_axi_wready,
  input wire logic [1:0]        s_axi_bresp,
  input wire logic              s_axi_bvalid,
  // Engine side and pins
  input wire logic              wait_mode,
  input wire logic              abort_idle,
  input wire logic              sck_edge,
  input wire logic              rx_from_mosi,
  input wire logic              mode_fault_flag,
  input wire logic              sel_pin_oe,
  input wire logic              mosi_oe,
  input wire logic              miso_oe
);
  logic [ADDR_W-3:0] idx_r, idx_nxt;
  logic [8:0]        wd_r, wd_nxt;
  logic [7:0]        ctrl_r, ctrl_nxt, rate_r, rate_nxt, mode_r, mode_nxt;
  logic              bv_r, commit, chg, on, sl;

  // Shadows move when the response first shows, like the pin enables
  always_comb begin
    idx_nxt  = (s_axi_awvalid && s_axi_awready) ? s_axi_awaddr[ADDR_W-1:2] : idx_r;
    wd_nxt   = (s_axi_wvalid && s_axi_wready) ? {s_axi_wstrb[0], s_axi_wdata[7:0]} : wd_r;
    commit   = s_axi_bvalid && !bv_r && s_axi_bresp == `RESP_OKAY && wd_r[8];
    on       = mode_r[`BIT_MASTER] && mode_r[`BIT_ENABLE];
    sl       = mode_r[`BIT_ENABLE] && !mode_r[`BIT_MASTER];
    ctrl_nxt = (commit && 12'(idx_r) == `IDX_CTRL_TWO) ? wd_r[7:0] & `CTRL_TWO_MASK : ctrl_r;
    rate_nxt = (commit && 12'(idx_r) == `IDX_RATE_SEL) ? wd_r[7:0] & `RATE_SEL_MASK : rate_r;
    mode_nxt = (commit && 12'(idx_r) == `IDX_MODE) ? wd_r[7:0] & `MODE_MASK : mode_r;
    // Line enable only counts while single-line mode was already on
    chg = on && (((ctrl_nxt ^ ctrl_r) & {3'h0, 1'b1, ctrl_r[0], 2'h0, 1'b1}) != 8'h00
                 || rate_nxt != rate_r);
  end

  // Shadow registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      idx_r  <= '0;
      wd_r   <= '0;
      bv_r   <= 1'b0;
      ctrl_r <= `CTRL_TWO_RST;
      rate_r <= `RATE_SEL_RST;
      mode_r <= `MODE_RST;
    end else begin
      idx_r  <= idx_nxt;
      wd_r   <= wd_nxt;
      bv_r   <= s_axi_bvalid;
      ctrl_r <= ctrl_nxt;
      rate_r <= rate_nxt;
      mode_r <= mode_nxt;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_master_normal: assert property (on && !ctrl_r[0] |->
    mosi_oe && !miso_oe && !rx_from_mosi) else $error("master normal pins wrong");
  a_master_single: assert property (on && ctrl_r[0] |->
    mosi_oe == ctrl_r[3] && !miso_oe && rx_from_mosi) else $error("master single-line pins wrong");
  a_slave_pins: assert property (sl |-> !mosi_oe &&
    miso_oe == (!ctrl_r[0] || ctrl_r[3]) && rx_from_mosi == !ctrl_r[0])
    else $error("slave pins wrong");
  a_select_input_only: assert property (mode_r[1] && !(on && ctrl_r[4] && mode_r[3])
    |-> !sel_pin_oe) else $error("select driven when it must not be");
  a_select_output_on: assert property (on && ctrl_r[4] && mode_r[3] |-> sel_pin_oe)
    else $error("select output not driven");
  a_fault_gated: assert property (mode_fault_flag |-> ctrl_nxt[4] || ctrl_r[4])
    else $error("mode fault without fault-detect enable");
  a_abort_on_change: assert property (chg |-> ##[0:1] abort_idle)
    else $error("no abort after field change in master");
  a_wait_holds_clock: assert property (wait_mode && $past(wait_mode) && ctrl_r[1]
    && $past(ctrl_r[1]) |-> !sck_edge) else $error("serial clock ran in wait mode");
endmodule : spi_rate_checker

bind spi_rate_ctrl spi_rate_checker #(.ADDR_W(ADDR_W)) u_checker (
  .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
  .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .wait_mode,
  .abort_idle, .sck_edge, .rx_from_mosi, .mode_fault_flag, .sel_pin_oe, .mosi_oe, .miso_oe
);
`default_nettype wire

/* File: spi_peer_model.sv */
// External serial peer: select line with pull-up, data drive, clock timing.
// Assumes the pins are sampled on the bench clock.
`timescale 1ns/1ps
`default_nettype none

module spi_peer_model (
  // Clock
  input  wire logic aclk,
  // Device pins
  input  wire logic sel_pin_out,
  input  wire logic sel_pin_oe,
  input  wire logic sck_pin_out,
  input  wire logic mosi_oe,
  input  wire logic miso_oe,
  // Bench command
  input  wire logic pull_sel_low,
  // Peer side
  output logic      sel_wire,
  output logic      peer_mosi_oe,
  output logic      peer_miso_oe,
  output var int    half_cyc
);
  int   cnt  = 0;
  logic last = 1'b0;

  // Pull-up wins unless someone drives the select line
  assign sel_wire     = sel_pin_oe ? sel_pin_out : !pull_sel_low;
  // Peer keeps off a data line while our buffer drives it
  assign peer_mosi_oe = !mosi_oe;
  assign peer_miso_oe = !miso_oe;

  // Cycles between two serial clock toggles
  initial half_cyc = 0;
  always @(posedge aclk) begin
    if (sck_pin_out !== last) begin
      half_cyc <= cnt;
      cnt      <= 1;
    end else begin
      cnt <= cnt + 1;
    end
    last <= sck_pin_out;
  end
endmodule : spi_peer_model
`default_nettype wire

/* File: tb_spi_rate_ctrl.sv */
// Self-checking bench for the control-two and bit-rate block.
// Registers over the AXI4-Lite tasks; peer model on the pins.
`timescale 1ns/1ps
`default_nettype none
`include "spi_rate_params.svh"

module tb_spi_rate_ctrl;
  logic        aclk = 1'b0, aresetn = 1'b0;
  logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, got;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic        s_axi_arvalid = 0, s_axi_rready = 0;
  logic        wait_mode = 0, xfer_start = 0, xfer_busy = 0, sel_level = 1, pull_low = 0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        abort_idle, sck_edge, rx_from_mosi, mode_fault_flag, irq, sel_wire;
  logic        sel_pin_out, sel_pin_oe, sck_pin_out, sck_pin_oe, mosi_oe, miso_oe;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [7:0]  rates [4] = '{8'h00, 8'h13, 8'h72, 8'h07};
  int          miscompares = 0, checks = 0, half_cyc, n, div;

  spi_rate_ctrl #(.ADDR_W(12)) u_dut (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .wait_mode, .xfer_start, .xfer_busy, .sel_level, .abort_idle, .sck_edge,
    .rx_from_mosi, .mode_fault_flag, .irq, .sel_pin_in(sel_wire), .sel_pin_out, .sel_pin_oe,
    .sck_pin_out, .sck_pin_oe, .mosi_oe, .miso_oe
  );
  spi_peer_model u_peer (
    .aclk, .sel_pin_out, .sel_pin_oe, .sck_pin_out, .mosi_oe, .miso_oe,
    .pull_sel_low(pull_low), .sel_wire, .peer_mosi_oe(), .peer_miso_oe(), .half_cyc
  );

  // Free-running bus clock
  always #5 aclk = ~aclk;

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // Each access starts an edge later so no strobe is set twice in one step
  task automatic wr(input logic [11:0] idx, input logic [7:0] d, input logic [1:0] er);
    @(posedge aclk);
    s_axi_awaddr  <= {idx[9:0], 2'h0};
    s_axi_wdata   <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk("bresp", 32'(s_axi_bresp), 32'(er));
  endtask : wr

  task automatic rd(input logic [11:0] idx, input logic [1:0] er);
    @(posedge aclk);
    s_axi_araddr  <= {idx[9:0], 2'h0};
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    got = s_axi_rdata;
    chk("rresp", 32'(s_axi_rresp), 32'(er));
  endtask : rd

  task automatic rdc(input logic [11:0] idx, input logic [31:0] exp);
    rd(idx, `RESP_OKAY);
    chk("rdata", got, exp);
  endtask : rdc

  task automatic start_xfer;
    @(posedge aclk);
    xfer_busy  <= 1'b1;
    xfer_start <= 1'b1;
    @(posedge aclk);
    xfer_start <= 1'b0;
  endtask : start_xfer

  task automatic count_edges;
    n = 0;
    repeat (20) begin
      @(posedge aclk);
      n += int'(sck_edge);
    end
  endtask : count_edges

  task automatic end_of_test;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : end_of_test

  // Main sequence
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    rdc(`IDX_CTRL_TWO, 32'h0);
    rdc(`IDX_RATE_SEL, 32'h0);
    wr(`IDX_CTRL_TWO, 8'hFF, `RESP_OKAY);
    rdc(`IDX_CTRL_TWO, 32'h1B);
    wr(`IDX_RATE_SEL, 8'hFF, `RESP_OKAY);
    rdc(`IDX_RATE_SEL, 32'h77);
    s_axi_wstrb <= 4'h0;
    wr(`IDX_CTRL_TWO, 8'h00, `RESP_OKAY);
    s_axi_wstrb <= 4'hF;
    rdc(`IDX_CTRL_TWO, 32'h1B);
    wr(12'h0E8, 8'h5A, `RESP_SLVERR);
    rd(12'h0E8, `RESP_SLVERR);
    chk("unmapped", got, 32'h0);
    // Every pin setup: master or slave, single-line or not, buffer on or off
    for (int i = 0; i < 8; i++) begin
      wr(`IDX_CTRL_TWO, {4'h0, i[0], 2'h0, i[1]}, `RESP_OKAY);
      wr(`IDX_MODE, {6'h0, 1'b1, i[2]}, `RESP_OKAY);
      repeat (2) @(posedge aclk);
      chk("pins", 32'({mosi_oe, miso_oe, rx_from_mosi, sel_pin_oe}), i[2] ?
          32'({i[1] ? i[0] : 1'b1, 1'b0, i[1], 1'b0}) : 32'({1'b0, i[1] ? i[0] : 1'b1, !i[1], 1'b0}));
    end
    // Select as output, then as fault input, then unused
    wr(`IDX_CTRL_TWO, 8'h10, `RESP_OKAY);
    wr(`IDX_MODE, 8'h0B, `RESP_OKAY);
    sel_level <= 1'b0;
    repeat (3) @(posedge aclk);
    chk("sel out", 32'({sel_pin_oe, sel_wire}), 32'h2);
    for (int k = 0; k < 2; k++) begin
      wr(`IDX_CTRL_TWO, k ? 8'h00 : 8'h10, `RESP_OKAY);
      wr(`IDX_MODE, 8'h03, `RESP_OKAY);
      rd(`IDX_IRQ_STATUS, `RESP_OKAY);
      pull_low <= 1'b1;
      repeat (8) @(posedge aclk);
      pull_low <= 1'b0;
      repeat (5) @(posedge aclk);
      rdc(`IDX_IRQ_STATUS, k ? 32'h0 : 32'h2);
    end
    // Bit rate from both fields; peer measures the half period
    foreach (rates[k]) begin
      xfer_busy <= 1'b0;
      wr(`IDX_RATE_SEL, rates[k], `RESP_OKAY);
      start_xfer();
      div = (int'(rates[k][6:4]) + 1) * (2 ** (int'(rates[k][2:0]) + 1));
      repeat (3 * div) @(posedge aclk);
      chk("half period", half_cyc, div / 2);
    end
    // Rate change mid-transfer aborts; clock rests high; interrupt unmasked then masked
    xfer_busy <= 1'b0;
    wr(`IDX_MODE, 8'h07, `RESP_OKAY);
    wr(`IDX_RATE_SEL, 8'h00, `RESP_OKAY);
    wr(`IDX_IRQ_MASK, 8'h01, `RESP_OKAY);
    for (int k = 0; k < 2; k++) begin
      rd(`IDX_IRQ_STATUS, `RESP_OKAY);
      repeat (2) @(posedge aclk);
      chk("irq idle", irq, 32'h0);
      start_xfer();
      repeat (9) @(posedge aclk);
      wr(`IDX_RATE_SEL, k ? 8'h00 : 8'h01, `RESP_OKAY);
      repeat (3) @(posedge aclk);
      chk("rest", 32'({irq, sck_pin_out}), k ? 32'h1 : 32'h3);
      @(posedge aclk);
      chk("rest held", sck_pin_out, 32'h1);
      rdc(`IDX_IRQ_STATUS, 32'h1);
      wr(`IDX_IRQ_MASK, 8'h00, `RESP_OKAY);
    end
    // Wait-mode clock stop, then clock keeps running with the stop bit clear
    wr(`IDX_CTRL_TWO, 8'h02, `RESP_OKAY);
    start_xfer();
    wait_mode <= 1'b1;
    repeat (3) @(posedge aclk);
    count_edges();
    chk("stopped", n, 32'h0);
    wr(`IDX_CTRL_TWO, 8'h00, `RESP_OKAY);
    count_edges();
    chk("running", 32'(n != 0), 32'h1);
    end_of_test();
  end

  // Watchdog against a hung handshake
  initial begin
    repeat (20000) @(posedge aclk);
    miscompares++;
    end_of_test();
  end
endmodule : tb_spi_rate_ctrl
`default_nettype wire
